/* hdl/sdce_encoder.v */
// diagnostic code encoder: condition flags in, 10-bit code word and type out
// assumes flags come synchronous from the safety state machine on i_clk
// What this block does
// - cross circuit pair 6 a/b gives error
// - start-input cross circuit gives its error code
// - sync window expired, one input off: alert
// - both active but too late: alert
// - inputs and outputs off: status code
// - pair 1 awaiting change: terminal codes
// - pair 2 awaiting change: terminal codes
// - pair 3 awaiting change: terminal codes
// - pair 4 awaiting change: terminal codes
// - pair 5 awaiting change: terminal codes
// - pair 6 awaiting change: terminal codes
// - antivalent pair: first-terminal code means both
// - waiting startup test, waiting rising start edge
// - monitored start active: wait falling edge code
// - run with outputs energized: run code
// - each code other than idle carries error, alert or status
`timescale 1ns/1ns
`include "sdce_defines.vh"
module sdce_encoder (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // cross circuit detections
   input wire i_xc_pair6_input_a,
   input wire i_xc_pair6_input_b,
   input wire i_xc_start,
   // synchronization faults
   input wire i_sync_open,
   input wire i_sync_late,
   // expected changes per pair, bit 0 is pair 1
   input wire [5:0] i_wait_input_a,
   input wire [5:0] i_wait_input_b,
   input wire [5:0] i_antivalent,
   // operating state flags
   input wire i_inputs_off,
   input wire i_wait_test,
   input wire i_wait_rise,
   input wire i_wait_fall,
   input wire i_run,
   // diagnostic word
   output reg [`SDCE_CODE_W-1:0] o_code,
   output reg [`SDCE_TYPE_W-1:0] o_type,
   output reg o_change
);
   // ----------------------------------------
   // latched errors
   // ----------------------------------------
   wire [2:0] err_latched;
   reg [2:0] err_seen;
   wire [2:0] err_now;
   // a detection seen combinationally too, so it is not a cycle late
   assign err_now = {i_xc_start, i_xc_pair6_input_b, i_xc_pair6_input_a};

   // errors stay until a power cycle clears them
   sdce_error_latch #(
      .N(3)
   ) u_lat (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_detect(err_now),
      .o_latched(err_latched)
   );

   always @* begin
      err_seen = err_latched | err_now;
   end

   // ----------------------------------------
   // pair expectations
   // ----------------------------------------
   // antivalent: both terminals change, reported on the first-terminal code alone
   wire [5:0] eff_a;
   wire [5:0] eff_b;
   assign eff_a = i_wait_input_a | (i_antivalent & i_wait_input_b);
   assign eff_b = i_wait_input_b & ~i_antivalent;

   wire pick_valid;
   wire [`SDCE_CODE_W-1:0] pick_code;

   sdce_status_pick u_pick (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wait_a(eff_a),
      .i_wait_b(eff_b),
      .o_valid(pick_valid),
      .o_code(pick_code)
   );

   // ----------------------------------------
   // align other flags with the picker's register stage
   // ----------------------------------------
   reg sync_open_q;
   reg sync_late_q;
   reg inputs_off_q;
   reg wait_test_q;
   reg wait_rise_q;
   reg wait_fall_q;
   reg run_q;
   reg [2:0] err_q;

   always @(posedge i_clk) begin
      if (i_srst) begin
         sync_open_q <= 1'b0;
         sync_late_q <= 1'b0;
         inputs_off_q <= 1'b0;
         wait_test_q <= 1'b0;
         wait_rise_q <= 1'b0;
         wait_fall_q <= 1'b0;
         run_q <= 1'b0;
         err_q <= 3'h0;
      end else begin
         sync_open_q <= i_sync_open;
         sync_late_q <= i_sync_late;
         inputs_off_q <= i_inputs_off;
         wait_test_q <= i_wait_test;
         wait_rise_q <= i_wait_rise;
         wait_fall_q <= i_wait_fall;
         run_q <= i_run;
         err_q <= err_seen;
      end
   end

   // ----------------------------------------
   // priority selection
   // ----------------------------------------
   reg [`SDCE_CODE_W-1:0] next_code;
   reg [`SDCE_TYPE_W-1:0] next_type;

   always @* begin
      next_code = `SDCE_CODE_IDLE;
      next_type = `SDCE_TYPE_NONE;
      // errors first, then alerts, then status
      if (err_q[0]) begin
         next_code = `SDCE_ERR_XC_P6A;
         next_type = `SDCE_TYPE_ERROR;
      end else if (err_q[1]) begin
         next_code = `SDCE_ERR_XC_P6B;
         next_type = `SDCE_TYPE_ERROR;
      end else if (err_q[2]) begin
         next_code = `SDCE_ERR_XC_START;
         next_type = `SDCE_TYPE_ERROR;
      end else if (sync_open_q) begin
         next_code = `SDCE_ALR_SYNC_OPEN;
         next_type = `SDCE_TYPE_ALERT;
      end else if (sync_late_q) begin
         next_code = `SDCE_ALR_SYNC_LATE;
         next_type = `SDCE_TYPE_ALERT;
      end else if (run_q) begin
         next_code = `SDCE_STS_RUN;
         next_type = `SDCE_TYPE_STATUS;
      end else if (wait_fall_q) begin
         next_code = `SDCE_STS_WAIT_FALL;
         next_type = `SDCE_TYPE_STATUS;
      end else if (pick_valid) begin
         next_code = pick_code;
         next_type = `SDCE_TYPE_STATUS;
      end else if (wait_test_q) begin
         next_code = `SDCE_STS_WAIT_TEST;
         next_type = `SDCE_TYPE_STATUS;
      end else if (wait_rise_q) begin
         next_code = `SDCE_STS_WAIT_RISE;
         next_type = `SDCE_TYPE_STATUS;
      end else if (inputs_off_q) begin
         next_code = `SDCE_STS_INPUTS_OFF;
         next_type = `SDCE_TYPE_STATUS;
      end
   end

   // ----------------------------------------
   // output register
   // ----------------------------------------
   // word only moves when the chosen condition moves
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_code <= `SDCE_CODE_IDLE;
         o_type <= `SDCE_TYPE_NONE;
         o_change <= 1'b0;
      end else begin
         o_code <= next_code;
         o_type <= next_type;
         o_change <= (next_code != o_code) || (next_type != o_type);
      end
   end
endmodule // sdce_encoder

/* hdl/sdce_defines.vh */
// diagnostic code words, message types and field widths for the code encoder
// assumes inclusion by bare name from the design files
`ifndef SDCE_DEFINES_VH
`define SDCE_DEFINES_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define SDCE_CODE_W 10
`define SDCE_TYPE_W 2
`define SDCE_NPAIRS 6

// ----------------------------------------
// message types
// ----------------------------------------
`define SDCE_TYPE_NONE 2'h0
`define SDCE_TYPE_STATUS 2'h1
`define SDCE_TYPE_ALERT 2'h2
`define SDCE_TYPE_ERROR 2'h3

// ----------------------------------------
// error codes
// ----------------------------------------
`define SDCE_ERR_XC_P6A 10'h09d
`define SDCE_ERR_XC_P6B 10'h09c
`define SDCE_ERR_XC_START 10'h0b0

// ----------------------------------------
// alert codes
// ----------------------------------------
`define SDCE_ALR_SYNC_OPEN 10'h0b3
`define SDCE_ALR_SYNC_LATE 10'h0a7

// ----------------------------------------
// status codes
// ----------------------------------------
`define SDCE_STS_INPUTS_OFF 10'h0b7
`define SDCE_STS_P1A 10'h0b5
`define SDCE_STS_P1B 10'h0b4
`define SDCE_STS_P2A 10'h0bc
`define SDCE_STS_P2B 10'h0bd
`define SDCE_STS_P3A 10'h0bf
`define SDCE_STS_P3B 10'h0be
`define SDCE_STS_P4A 10'h0ba
`define SDCE_STS_P4B 10'h0bb
`define SDCE_STS_P5A 10'h0b9
`define SDCE_STS_P5B 10'h0b8
`define SDCE_STS_P6A 10'h0a8
`define SDCE_STS_P6B 10'h0a9
`define SDCE_STS_WAIT_TEST 10'h0ab
`define SDCE_STS_WAIT_RISE 10'h0aa
`define SDCE_STS_WAIT_FALL 10'h0ae
`define SDCE_STS_RUN 10'h0af
`define SDCE_CODE_IDLE 10'h000

`endif

/* hdl/sdce_error_latch.v */
// sticky cross-circuit error flags, cleared only by reset (power cycle)
// assumes condition inputs are synchronous one-cycle or level detections
`timescale 1ns/1ns
module sdce_error_latch #(
   parameter N = 3
) (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // detections in, latched flags out
   input wire [N-1:0] i_detect,
   output reg [N-1:0] o_latched
);
   // ----------------------------------------
   // one latch per source
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_lat
         always @(posedge i_clk) begin
            if (i_srst) begin
               o_latched[g] <= 1'b0;
            end else if (i_detect[g]) begin
               o_latched[g] <= 1'b1;
            end
         end
      end
   endgenerate
endmodule // sdce_error_latch

/* hdl/sdce_status_pick.v */
// picks the lowest-numbered pair that awaits a change and returns its status code
// assumes pair flags are levels from the safety state machine
`timescale 1ns/1ns
`include "sdce_defines.vh"
module sdce_status_pick (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // per-pair expectation flags, bit 0 is pair 1
   input wire [5:0] i_wait_a,
   input wire [5:0] i_wait_b,
   // registered choice
   output reg o_valid,
   output reg [`SDCE_CODE_W-1:0] o_code
);
   // ----------------------------------------
   // code lookup
   // ----------------------------------------
   function [`SDCE_CODE_W-1:0] pair_code;
      input [2:0] idx;
      input term_b;
      begin
         case ({idx, term_b})
            4'h0: pair_code = `SDCE_STS_P1A;
            4'h1: pair_code = `SDCE_STS_P1B;
            4'h2: pair_code = `SDCE_STS_P2A;
            4'h3: pair_code = `SDCE_STS_P2B;
            4'h4: pair_code = `SDCE_STS_P3A;
            4'h5: pair_code = `SDCE_STS_P3B;
            4'h6: pair_code = `SDCE_STS_P4A;
            4'h7: pair_code = `SDCE_STS_P4B;
            4'h8: pair_code = `SDCE_STS_P5A;
            4'h9: pair_code = `SDCE_STS_P5B;
            4'ha: pair_code = `SDCE_STS_P6A;
            4'hb: pair_code = `SDCE_STS_P6B;
            default: pair_code = `SDCE_CODE_IDLE;
         endcase
      end
   endfunction

   reg next_valid;
   reg [`SDCE_CODE_W-1:0] next_code;
   integer k;

   // scan from pair 6 down so pair 1 wins; terminal a wins over b
   always @* begin
      next_valid = 1'b0;
      next_code = `SDCE_CODE_IDLE;
      for (k = 5; k >= 0; k = k - 1) begin
         if (i_wait_b[k]) begin
            next_valid = 1'b1;
            next_code = pair_code(k[2:0], 1'b1);
         end
         if (i_wait_a[k]) begin
            next_valid = 1'b1;
            next_code = pair_code(k[2:0], 1'b0);
         end
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         o_valid <= 1'b0;
         o_code <= `SDCE_CODE_IDLE;
      end else begin
         o_valid <= next_valid;
         o_code <= next_code;
      end
   end
endmodule // sdce_status_pick

/* bench/sdce_encoder_props.sv */
// checker for the code encoder: ties code word and type to the condition inputs
// assumes bind onto sdce_encoder and a 2-cycle input-to-code latency
`timescale 1ns/1ns
`include "sdce_defines.vh"
module sdce_encoder_props (
   // watched ports
   input wire i_clk,
   input wire i_srst,
   input wire i_xc_pair6_input_a,
   input wire i_xc_start,
   input wire i_sync_open,
   input wire i_sync_late,
   input wire i_run,
   input wire [`SDCE_CODE_W-1:0] o_code,
   input wire [`SDCE_TYPE_W-1:0] o_type,
   input wire o_change
);
   // two edges out of reset before inputs can reach the word
   reg [1:0] live;
   wire err = o_type == `SDCE_TYPE_ERROR;
   always @(posedge i_clk) live <= i_srst ? 2'h0 : {live[0], 1'b1};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_xc_pair6a_code: assert property (live[1] && $past(i_xc_pair6_input_a, 2)
      |-> o_code == `SDCE_ERR_XC_P6A && err) else $error("pair 6 a error code wrong");
   a_xc_start_err: assert property (live[1] && $past(i_xc_start, 2) |-> err)
      else $error("start cross circuit not an error");
   a_sync_open_alert: assert property (live[1] && $past(i_sync_open, 2) && !err
      |-> o_code == `SDCE_ALR_SYNC_OPEN && o_type == `SDCE_TYPE_ALERT) else $error("open alert");
   a_sync_late_alert: assert property (live[1] && $past(i_sync_late, 2)
      && !$past(i_sync_open, 2) && !err |-> o_code == `SDCE_ALR_SYNC_LATE)
      else $error("late alert wrong");
   a_run_status: assert property (live[1] && $past(i_run, 2) && !$past(i_sync_open, 2)
      && !$past(i_sync_late, 2) && !err |-> o_code == `SDCE_STS_RUN
      && o_type == `SDCE_TYPE_STATUS) else $error("run status wrong");
   a_error_sticky: assert property (err |=> err) else $error("error dropped");
   // the pulse rises on the same edge as the new word, not one edge later
   a_change_pulse: assert property (o_change == ($changed(o_code) || $changed(o_type)))
      else $error("change pulse does not match word change");
   a_alert_type: assert property ((o_code == `SDCE_ALR_SYNC_OPEN
      || o_code == `SDCE_ALR_SYNC_LATE) == (o_type == `SDCE_TYPE_ALERT)) else $error("alert type");
   a_error_type: assert property ((o_code == `SDCE_ERR_XC_P6A
      || o_code == `SDCE_ERR_XC_P6B
      || o_code == `SDCE_ERR_XC_START) == err) else $error("error type");
   c_error: cover property (err);
   c_run: cover property (o_code == `SDCE_STS_RUN);
   c_alert: cover property (o_type == `SDCE_TYPE_ALERT);
   c_change: cover property (o_change);
endmodule // sdce_encoder_props

/* bench/sdce_monitor.sv */
// monitoring reader of the diagnostic word: keeps the last reported code and type
// assumes the encoder's clock; a power cycle is modelled by i_srst
`timescale 1ns/1ns
`include "sdce_defines.vh"
module sdce_monitor (
   // clock and power cycle
   input wire i_clk,
   input wire i_srst,
   // encoder word
   input wire [9:0] i_code,
   input wire [1:0] i_type,
   input wire i_change,
   // what the operator sees
   output reg [9:0] o_last_code,
   output reg [1:0] o_last_type,
   output reg o_need_cycle
);
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_last_code <= 10'h000;
         o_last_type <= 2'h0;
         o_need_cycle <= 1'b0;
      end else if (i_change) begin
         o_last_code <= i_code;
         o_last_type <= i_type;
         // wiring fixed, then power cycle before resuming
         o_need_cycle <= i_type == `SDCE_TYPE_ERROR;
      end
   end
endmodule // sdce_monitor

/* bench/sdce_encoder_tb.sv */
// self-checking bench for the diagnostic code encoder
// assumes sdce_encoder, sdce_monitor and the props checker are compiled alongside
`timescale 1ns/1ns
`include "sdce_defines.vh"
module sdce_encoder_tb;
   reg i_clk = 1'b0;
   reg i_srst = 1'b1;
   reg [2:0] xc = 3'h0; // pair6 a, pair6 b, start
   reg [1:0] sy = 2'h0; // open, late
   reg [5:0] wa = 6'h00;
   reg [5:0] wb = 6'h00;
   reg [5:0] av = 6'h00;
   reg [4:0] st = 5'h00; // off, test, rise, fall, run
   wire [9:0] o_code;
   wire [1:0] o_type;
   wire o_change;
   wire [9:0] mon_code;
   wire [1:0] mon_type;
   wire need_cycle;
   wire [11:0] word = {o_type, o_code};
   wire [59:0] pa = {`SDCE_STS_P6A, `SDCE_STS_P5A, `SDCE_STS_P4A,
      `SDCE_STS_P3A, `SDCE_STS_P2A, `SDCE_STS_P1A};
   wire [59:0] pb = {`SDCE_STS_P6B, `SDCE_STS_P5B, `SDCE_STS_P4B,
      `SDCE_STS_P3B, `SDCE_STS_P2B, `SDCE_STS_P1B};
   wire [29:0] ec = {`SDCE_ERR_XC_START, `SDCE_ERR_XC_P6B, `SDCE_ERR_XC_P6A};
   integer err_count = 0;
   integer n_checks = 0;
   integer cycles = 0;
   integer k;
   always #10 i_clk = ~i_clk;
   sdce_encoder i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_xc_pair6_input_a(xc[2]),
      .i_xc_pair6_input_b(xc[1]), .i_xc_start(xc[0]), .i_sync_open(sy[1]), .i_sync_late(sy[0]),
      .i_wait_input_a(wa), .i_wait_input_b(wb), .i_antivalent(av), .i_inputs_off(st[4]),
      .i_wait_test(st[3]), .i_wait_rise(st[2]), .i_wait_fall(st[1]), .i_run(st[0]),
      .o_code(o_code), .o_type(o_type), .o_change(o_change));
   sdce_monitor i_mon (.i_clk(i_clk), .i_srst(i_srst), .i_code(o_code), .i_type(o_type),
      .i_change(o_change), .o_last_code(mon_code), .o_last_type(mon_type),
      .o_need_cycle(need_cycle));
   task cyc(input integer n); begin
      repeat (n) @(posedge i_clk);
      #2;
   end
   endtask
   task check(input [11:0] seen, input [11:0] exp); begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   // inputs land on the next edge, the word one edge later; looked at after a third
   task put(input [2:0] x, input [1:0] s, input [5:0] a, input [5:0] b, input [5:0] v,
      input [4:0] t); begin
      xc = x;
      sy = s;
      wa = a;
      wb = b;
      av = v;
      st = t;
      cyc(3);
   end
   endtask
   task power_cycle; begin
      i_srst = 1'b1;
      cyc(2);
      i_srst = 1'b0;
   end
   endtask
   task t_status; begin
      put(0, 0, 0, 0, 0, 5'h10);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_INPUTS_OFF});
      put(0, 0, 0, 0, 0, 5'h08);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_WAIT_TEST});
      put(0, 0, 0, 0, 0, 5'h04);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_WAIT_RISE});
      put(0, 0, 0, 0, 0, 5'h02);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_WAIT_FALL});
      put(0, 0, 0, 0, 0, 5'h1f);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_RUN});
      // change pulse stands only in the cycle the new word first shows
      st = 5'h0e;
      cyc(2);
      check({11'h0, o_change}, 12'h001);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_WAIT_FALL});
      cyc(4);
      check({11'h0, o_change}, 12'h000);
      check(word, {`SDCE_TYPE_STATUS, `SDCE_STS_WAIT_FALL});
      check({mon_type, mon_code}, {`SDCE_TYPE_STATUS, `SDCE_STS_WAIT_FALL});
      $display("t_status done");
   end
   endtask
   task t_pairs; begin
      for (k = 0; k < 6; k = k + 1) begin
         put(0, 0, 6'h1 << k, 0, 0, 5'h08);
         check(word, {2'h1, pa[k*10 +: 10]});
         put(0, 0, 0, 6'h1 << k, 0, 0);
         check(word, {2'h1, pb[k*10 +: 10]});
      end
      put(0, 0, 0, 6'h04, 6'h04, 0);
      check(word, {2'h1, `SDCE_STS_P3A});
      put(0, 0, 6'h20, 6'h20, 6'h20, 0);
      check(word, {2'h1, `SDCE_STS_P6A});
      put(0, 0, 6'h02, 6'h01, 0, 5'h1c);
      check(word, {2'h1, `SDCE_STS_P1B});
      $display("t_pairs done");
   end
   endtask
   task t_alerts; begin
      put(0, 2'h2, 6'h01, 0, 0, 5'h01);
      check(word, {`SDCE_TYPE_ALERT, `SDCE_ALR_SYNC_OPEN});
      put(0, 2'h1, 0, 0, 0, 5'h01);
      check(word, {`SDCE_TYPE_ALERT, `SDCE_ALR_SYNC_LATE});
      put(0, 2'h3, 0, 0, 0, 0);
      check(word, {`SDCE_TYPE_ALERT, `SDCE_ALR_SYNC_OPEN});
      $display("t_alerts done");
   end
   endtask
   task t_errors; begin
      for (k = 0; k < 3; k = k + 1) begin
         power_cycle;
         check(word, 12'h000);
         put(3'h4 >> k, 2'h3, 0, 0, 0, 5'h01);
         check(word, {2'h3, ec[k*10 +: 10]});
         put(0, 0, 0, 0, 0, 5'h01);
         check(word, {2'h3, ec[k*10 +: 10]});
         check({mon_type, mon_code}, {2'h3, ec[k*10 +: 10]});
      end
      put(3'h4, 0, 0, 0, 0, 0);
      check(word, {2'h3, `SDCE_ERR_XC_P6A});
      // a latched error is only left through a power cycle
      check({11'h0, need_cycle}, 12'h001);
      power_cycle;
      put(0, 0, 0, 0, 0, 5'h01);
      check(word, {2'h1, `SDCE_STS_RUN});
      $display("t_errors done");
   end
   endtask
   task summarize; begin
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end endtask
   // the whole run needs about 120 cycles
   always @(posedge i_clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         err_count = err_count + 1;
         summarize;
      end
   end
   initial begin
      cyc(16);
      i_srst = 1'b0;
      t_status;
      t_pairs;
      t_alerts;
      t_errors;
      summarize;
   end
endmodule // sdce_encoder_tb
bind sdce_encoder sdce_encoder_props i_props (
   .i_clk(i_clk),
   .i_srst(i_srst),
   .i_xc_pair6_input_a(i_xc_pair6_input_a),
   .i_xc_start(i_xc_start),
   .i_sync_open(i_sync_open),
   .i_sync_late(i_sync_late),
   .i_run(i_run),
   .o_code(o_code),
   .o_type(o_type),
   .o_change(o_change)
);
